/* File: design/pump_io_ctrl.sv */
// Functional notes
// - Trigger and direction inputs ignored while editing or during an alarm.
// - Foot-switch mode: each trigger falling edge toggles run and stop.
// - Level mode: trigger falling edge stops, rising edge starts.
// - Start-only mode: falling edge starts; then nothing until start re-permitted.
// - Stop-only mode: falling edge stops; it never starts the program.
// - Motor mode 0: motor output high only while actually pumping.
// - Motor mode 1: motor output high while pumping or pause timer runs.
// - Direction mode 0: fall withdraw to infuse, rise infuse to withdraw.
// - Direction mode 1: rise withdraw to infuse, fall infuse to withdraw.
// - Direction input acts only while a direction change is permitted.
// - Direction output low for withdraw, high for infuse.
// - Output-set function drives program output to the given level.
// - Level event jump: low now, or later falling edge, jumps until cancelled.
// - Edge event jump: either event edge jumps to the named phase.
// - Conditional function jumps when program input low, else continues.
// - Hold function waits for trigger activation, then resumes the program.
// - Host reads input levels and sets program output over the bus.
// - Inputs sampled every 50 ms; level accepted after 100 ms steady.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "pump_io_regs.svh"
module pump_io_ctrl #(
	parameter int unsigned SAMPLE_CYCLES =
		`SAMPLE_PERIOD_MS * (`CLK_HZ / 1000)
) (
	// Clock and reset.
	input  wire logic        MCLK_I,
	input  wire logic        RESETN_I,
	// Avalon-MM slave.
	input  wire logic [7:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Logic inputs.
	input  wire logic        TRIG_I,
	input  wire logic        DIR_I,
	input  wire logic        EVENT_I,
	input  wire logic        PROG_I,
	// Logic outputs.
	output logic             PROG_O,
	output logic             MOTOR_O,
	output logic             DIR_O
);
	localparam int unsigned STEADY_SAMPLES =
		`STEADY_MS / `SAMPLE_PERIOD_MS + 1;

	if (SAMPLE_CYCLES < 2) begin : g_chk
		$error("pump_io_ctrl: SAMPLE_CYCLES must be at least 2");
	end

	pump_io_pkg::pins_type      raw;
	pump_io_pkg::filt_type      filt;
	pump_io_pkg::run_state_type state_q;
	pump_io_pkg::run_state_type state_d;
	logic                       tick;

	logic                       ack_q;
	logic                       ack_d;
	logic [31:0]                rdata_q;
	logic [31:0]                rdata_d;
	logic                       wr_acc;
	logic [31:0]                cmd;
	logic [`PHASE_WIDTH-1:0]    cmd_phase;

	logic [`CFG_WIDTH-1:0]      cfg_q;
	logic [`CFG_WIDTH-1:0]      cfg_d;
	logic [`CTL_WIDTH-1:0]      ctl_q;
	logic [`CTL_WIDTH-1:0]      ctl_d;
	logic                       prog_out_q;
	logic                       prog_out_d;
	logic                       motor_q;
	logic                       motor_d;
	logic                       dir_q;
	logic                       dir_d;
	logic                       start_ok_q;
	logic                       start_ok_d;
	logic                       evn_q;
	logic                       evn_d;
	logic                       evs_q;
	logic                       evs_d;
	logic                       jump_q;
	logic                       jump_d;
	logic [`PHASE_WIDTH-1:0]    jphase_q;
	logic [`PHASE_WIDTH-1:0]    jphase_d;
	logic [`PHASE_WIDTH-1:0]    arm_phase_q;
	logic [`PHASE_WIDTH-1:0]    arm_phase_d;

	logic                       ignore;
	logic [1:0]                 trig_mode;
	logic                       start_ev;
	logic                       stop_ev;
	logic                       dir_ok;

	assign raw = '{prog: PROG_I, evt: EVENT_I, dir: DIR_I, trig: TRIG_I};

	// Sample strobe and glitch filter for all four inputs.
	tick_gen #(
		.PERIOD  (SAMPLE_CYCLES)
	) u_tick (
		.clk_i   (MCLK_I),
		.rst_n_i (RESETN_I),
		.tick_o  (tick)
	);

	// The filter keeps running while inputs are ignored.
	input_filter #(
		.WIDTH   (4),
		.STEADY  (STEADY_SAMPLES)
	) u_filt (
		.clk_i   (MCLK_I),
		.rst_n_i (RESETN_I),
		.tick_i  (tick),
		.raw_i   (raw),
		.level_o (filt.level),
		.rise_o  (filt.rise),
		.fall_o  (filt.fall)
	);

	// Every access takes one wait state, so read data can be registered.
	always_comb begin
		ack_d  = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
		wr_acc = AVS_WRITE_I & ack_q;
		cmd    = (wr_acc && AVS_ADDRESS_I == `OFS_CMD) ?
			AVS_WRITEDATA_I : 32'h0000_0000;
		cmd_phase = cmd[`CMD_PHASE_LSB +: `PHASE_WIDTH];
		rdata_d = rdata_q;
		if (AVS_READ_I && !ack_q) begin
			rdata_d = 32'h0000_0000;
			case (AVS_ADDRESS_I)
				`OFS_CONFIG:   rdata_d[`CFG_WIDTH-1:0] = cfg_q;
				`OFS_CONTROL:  rdata_d[`CTL_WIDTH-1:0] = ctl_q;
				`OFS_STATUS: begin
					rdata_d[3:0] = filt.level;
					rdata_d[`STS_RUN_BIT] =
						(state_q == pump_io_pkg::RUN_ACTIVE);
					rdata_d[`STS_HOLD_BIT] =
						(state_q == pump_io_pkg::RUN_HOLD);
					rdata_d[`STS_DIR_BIT]    = dir_q;
					rdata_d[`STS_PERMIT_BIT] = start_ok_q;
					rdata_d[`STS_EVN_BIT]    = evn_q;
					rdata_d[`STS_EVS_BIT]    = evs_q;
				end
				`OFS_PROG_OUT: rdata_d[0] = prog_out_q;
				`OFS_JUMP: begin
					rdata_d[`JMP_PEND_BIT] = jump_q;
					rdata_d[`JMP_PHASE_LSB +: `PHASE_WIDTH] = jphase_q;
				end
				default:       rdata_d = 32'h0000_0000;
			endcase
		end
	end

	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
	assign AVS_READDATA_O    = rdata_q;

	// Writable settings; unmapped writes are simply dropped.
	always_comb begin
		cfg_d      = cfg_q;
		ctl_d      = ctl_q;
		prog_out_d = prog_out_q;
		if (wr_acc) begin
			case (AVS_ADDRESS_I)
				`OFS_CONFIG:   cfg_d = AVS_WRITEDATA_I[`CFG_WIDTH-1:0];
				`OFS_CONTROL:  ctl_d = AVS_WRITEDATA_I[`CTL_WIDTH-1:0];
				`OFS_PROG_OUT: prog_out_d = AVS_WRITEDATA_I[0];
				default:       prog_out_d = prog_out_q;
			endcase
		end
		motor_d = ctl_q[`CTL_PUMPING_BIT] |
			(cfg_q[`CFG_MOTOR_MODE_BIT] & ctl_q[`CTL_PAUSE_TMR_BIT]);
	end

	// Editing or an alarm drops trigger and direction edges outright.
	assign ignore    = ctl_q[`CTL_EDIT_BIT] | ctl_q[`CTL_ALARM_BIT];
	assign trig_mode = cfg_q[`CFG_TRIG_LSB +: 2];
	assign dir_ok    = ctl_q[`CTL_DIR_OK_BIT] & ~ignore;

	// Trigger edges become start and stop requests per mode.
	always_comb begin
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		if (!ignore) begin
			case (trig_mode)
				`TRG_FOOT: begin
					start_ev = filt.fall.trig;
					stop_ev  = filt.fall.trig;
				end
				`TRG_LEVEL: begin
					start_ev = filt.rise.trig;
					stop_ev  = filt.fall.trig;
				end
				`TRG_START: start_ev = filt.fall.trig & start_ok_q;
				`TRG_STOP:  stop_ev  = filt.fall.trig;
				default: begin
					start_ev = 1'b0;
					stop_ev  = 1'b0;
				end
			endcase
		end
	end

	// Run state. In foot mode one edge is both requests and the state
	// picks the toggle direction. A held program resumes on activation.
	always_comb begin
		state_d    = state_q;
		start_ok_d = start_ok_q | cmd[`CMD_PERMIT_BIT];
		case (state_q)
			pump_io_pkg::RUN_STOPPED: begin
				if (cmd[`CMD_START_BIT] || start_ev) begin
					state_d = pump_io_pkg::RUN_ACTIVE;
				end
			end
			pump_io_pkg::RUN_ACTIVE: begin
				if (cmd[`CMD_HOLD_BIT]) begin
					state_d = pump_io_pkg::RUN_HOLD;
				end else if (cmd[`CMD_STOP_BIT] || stop_ev) begin
					state_d = pump_io_pkg::RUN_STOPPED;
				end
			end
			pump_io_pkg::RUN_HOLD: begin
				if (cmd[`CMD_STOP_BIT]) begin
					state_d = pump_io_pkg::RUN_STOPPED;
				end else if (cmd[`CMD_START_BIT] || start_ev) begin
					state_d = pump_io_pkg::RUN_ACTIVE;
				end
			end
			default: state_d = pump_io_pkg::RUN_STOPPED;
		endcase
		// A taken start-only trigger locks out further starts.
		if (start_ev && trig_mode == `TRG_START &&
				state_q != pump_io_pkg::RUN_ACTIVE) begin
			start_ok_d = cmd[`CMD_PERMIT_BIT];
		end
	end

	// Direction: the input follows the edge table of the chosen mode.
	always_comb begin
		dir_d = dir_q;
		if (dir_ok) begin
			if (!cfg_q[`CFG_DIR_MODE_BIT]) begin
				if (!dir_q && filt.fall.dir) begin
					dir_d = 1'b1;
				end else if (dir_q && filt.rise.dir) begin
					dir_d = 1'b0;
				end
			end else begin
				if (!dir_q && filt.rise.dir) begin
					dir_d = 1'b1;
				end else if (dir_q && filt.fall.dir) begin
					dir_d = 1'b0;
				end
			end
		end
		if (cmd[`CMD_INFUSE_BIT]) begin
			dir_d = 1'b1;
		end else if (cmd[`CMD_WITHDRAW_BIT]) begin
			dir_d = 1'b0;
		end
	end

	// Phase jumps. Only one event function is armed at a time, sharing
	// one target. A new jump wins over a clear in the same cycle.
	always_comb begin
		evn_d       = evn_q;
		evs_d       = evs_q;
		arm_phase_d = arm_phase_q;
		jphase_d    = jphase_q;
		jump_d      = jump_q;
		if (wr_acc && AVS_ADDRESS_I == `OFS_JUMP &&
				AVS_WRITEDATA_I[`JMP_PEND_BIT]) begin
			jump_d = 1'b0;
		end
		if (evn_q && filt.fall.evt) begin
			jump_d   = 1'b1;
			jphase_d = arm_phase_q;
		end
		if (evs_q && (filt.rise.evt || filt.fall.evt)) begin
			jump_d   = 1'b1;
			jphase_d = arm_phase_q;
		end
		if (cmd[`CMD_EVT_CANCEL_BIT]) begin
			evn_d = 1'b0;
			evs_d = 1'b0;
		end
		if (cmd[`CMD_EVN_ARM_BIT]) begin
			evn_d       = 1'b1;
			evs_d       = 1'b0;
			arm_phase_d = cmd_phase;
			if (!filt.level.evt) begin
				jump_d   = 1'b1;
				jphase_d = cmd_phase;
			end
		end else if (cmd[`CMD_EVS_ARM_BIT]) begin
			evn_d       = 1'b0;
			evs_d       = 1'b1;
			arm_phase_d = cmd_phase;
		end
		if (cmd[`CMD_COND_BIT] && !filt.level.prog) begin
			jump_d   = 1'b1;
			jphase_d = cmd_phase;
		end
	end

	// All state registers.
	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ack_q       <= 1'b0;
			rdata_q     <= 32'h0000_0000;
			cfg_q       <= `CFG_RESET;
			ctl_q       <= `CTL_RESET;
			prog_out_q  <= `PROG_OUT_RESET;
			motor_q     <= 1'b0;
			dir_q       <= `DIR_RESET;
			state_q     <= pump_io_pkg::RUN_STOPPED;
			start_ok_q  <= 1'b1;
			evn_q       <= 1'b0;
			evs_q       <= 1'b0;
			jump_q      <= 1'b0;
			jphase_q    <= '0;
			arm_phase_q <= '0;
		end else begin
			ack_q       <= ack_d;
			rdata_q     <= rdata_d;
			cfg_q       <= cfg_d;
			ctl_q       <= ctl_d;
			prog_out_q  <= prog_out_d;
			motor_q     <= motor_d;
			dir_q       <= dir_d;
			state_q     <= state_d;
			start_ok_q  <= start_ok_d;
			evn_q       <= evn_d;
			evs_q       <= evs_d;
			jump_q      <= jump_d;
			jphase_q    <= jphase_d;
			arm_phase_q <= arm_phase_d;
		end
	end

	// Outputs come straight from flip-flops.
	assign PROG_O  = prog_out_q;
	assign MOTOR_O = motor_q;
	assign DIR_O   = dir_q;

	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);

	a_ignore_trigger: assert property (
		(ignore && cmd == 32'h0000_0000) |=> $stable(state_q))
		else $error("run state changed while inputs ignored");

	a_foot_toggle: assert property (
		(!ignore && trig_mode == `TRG_FOOT && filt.fall.trig &&
		 cmd == 32'h0000_0000 && state_q == pump_io_pkg::RUN_ACTIVE)
		|=> state_q == pump_io_pkg::RUN_STOPPED)
		else $error("foot switch edge did not stop the program");

	a_level_start: assert property (
		(!ignore && trig_mode == `TRG_LEVEL && filt.rise.trig &&
		 cmd == 32'h0000_0000 && state_q == pump_io_pkg::RUN_STOPPED)
		|=> state_q == pump_io_pkg::RUN_ACTIVE)
		else $error("level mode rising edge did not start");

	a_start_lockout: assert property (
		(trig_mode == `TRG_START && !start_ok_q &&
		 !cmd[`CMD_START_BIT] && state_q == pump_io_pkg::RUN_STOPPED)
		|=> state_q == pump_io_pkg::RUN_STOPPED)
		else $error("start-only trigger started without permission");

	a_stop_only: assert property (
		(trig_mode == `TRG_STOP && !cmd[`CMD_START_BIT] &&
		 state_q == pump_io_pkg::RUN_STOPPED)
		|=> state_q == pump_io_pkg::RUN_STOPPED)
		else $error("stop-only trigger started the program");

	a_motor_output: assert property (
		##1 MOTOR_O == ($past(ctl_q[`CTL_PUMPING_BIT]) |
		 ($past(cfg_q[`CFG_MOTOR_MODE_BIT]) &
		  $past(ctl_q[`CTL_PAUSE_TMR_BIT]))))
		else $error("motor output does not follow mode");

	a_dir_recip: assert property (
		(dir_ok && !cfg_q[`CFG_DIR_MODE_BIT] && !dir_q &&
		 filt.fall.dir && cmd == 32'h0000_0000) |=> DIR_O)
		else $error("mode 0 falling edge did not select infuse");

	a_dir_dual: assert property (
		(dir_ok && cfg_q[`CFG_DIR_MODE_BIT] && dir_q &&
		 filt.fall.dir && cmd == 32'h0000_0000) |=> !DIR_O)
		else $error("mode 1 falling edge did not select withdraw");

	a_dir_locked: assert property (
		(!dir_ok && cmd == 32'h0000_0000) |=> $stable(dir_q))
		else $error("direction changed while not permitted");

	a_evn_jump: assert property (
		(cmd[`CMD_EVN_ARM_BIT] && !filt.level.evt) |=>
			(jump_q && jphase_q == $past(cmd_phase)))
		else $error("level event function did not jump");

	a_evs_jump: assert property (
		(evs_q && filt.rise.evt && cmd == 32'h0000_0000) |=>
			(jump_q && jphase_q == $past(arm_phase_q)))
		else $error("edge event function did not jump");

	a_cond_jump: assert property (
		(cmd[`CMD_COND_BIT] && filt.level.prog && !jump_q &&
		 !(evn_q || evs_q)) |=> !jump_q)
		else $error("conditional jumped with program input high");
endmodule

/* File: design/pump_io_regs.svh */
`ifndef PUMP_IO_REGS_SVH
`define PUMP_IO_REGS_SVH

// Clock rate and input sampling times.
`define CLK_HZ             125000000
`define SAMPLE_PERIOD_MS   50
`define STEADY_MS          100

// Byte offsets on the register bus.
`define OFS_CONFIG         8'h00
`define OFS_CONTROL        8'h04
`define OFS_STATUS         8'h08
`define OFS_PROG_OUT       8'h0c
`define OFS_CMD            8'h10
`define OFS_JUMP           8'h14

// Configuration fields and reset value.
`define CFG_TRIG_LSB       0
`define CFG_DIR_MODE_BIT   2
`define CFG_MOTOR_MODE_BIT 3
`define CFG_WIDTH          4
`define CFG_RESET          4'h0

// Trigger mode codes held in the configuration.
`define TRG_FOOT           2'h0
`define TRG_LEVEL          2'h1
`define TRG_START          2'h2
`define TRG_STOP           2'h3

// Control fields written by the pump firmware, and reset value.
`define CTL_EDIT_BIT       0
`define CTL_ALARM_BIT      1
`define CTL_PUMPING_BIT    2
`define CTL_PAUSE_TMR_BIT  3
`define CTL_DIR_OK_BIT     4
`define CTL_WIDTH          5
`define CTL_RESET          5'h00

// Command bits; each written one acts once.
`define CMD_START_BIT      0
`define CMD_STOP_BIT       1
`define CMD_INFUSE_BIT     2
`define CMD_WITHDRAW_BIT   3
`define CMD_EVN_ARM_BIT    4
`define CMD_EVS_ARM_BIT    5
`define CMD_EVT_CANCEL_BIT 6
`define CMD_COND_BIT       7
`define CMD_HOLD_BIT       8
`define CMD_PERMIT_BIT     9
`define CMD_PHASE_LSB      16

// Status and jump fields.
`define STS_RUN_BIT        4
`define STS_HOLD_BIT       5
`define STS_DIR_BIT        6
`define STS_PERMIT_BIT     7
`define STS_EVN_BIT        8
`define STS_EVS_BIT        9
`define JMP_PEND_BIT       0
`define JMP_PHASE_LSB      8
`define PHASE_WIDTH        8

// Output reset values; direction high means infuse.
`define DIR_RESET          1'b1
`define PROG_OUT_RESET     1'b0

`endif

/* File: design/pump_io_pkg.sv */
package pump_io_pkg;

	// Levels of the four control inputs; trigger is the low bit.
	typedef struct packed {
		logic prog;
		logic evt;
		logic dir;
		logic trig;
	} pins_type;

	// Filtered levels with their one-cycle edge pulses.
	typedef struct packed {
		pins_type level;
		pins_type rise;
		pins_type fall;
	} filt_type;

	// Pumping program run state.
	typedef enum logic [2:0] {
		RUN_STOPPED = 3'b001,
		RUN_ACTIVE  = 3'b010,
		RUN_HOLD    = 3'b100
	} run_state_type;

endpackage

/* File: design/tick_gen.sv */
`timescale 1ns/10ps
module tick_gen #(
	parameter int unsigned PERIOD = 6250000
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// One-cycle pulse every PERIOD cycles.
	output logic      tick_o
);
	localparam int unsigned CW = $clog2(PERIOD);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	if (PERIOD < 2) begin : g_chk
		$error("tick_gen: PERIOD must be at least 2");
	end

	// Free-running divider; the pulse is registered so it is glitch free.
	always_comb begin
		tick_d = (cnt_q == CW'(PERIOD - 1));
		cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
endmodule

/* File: design/input_filter.sv */
`timescale 1ns/10ps
module input_filter #(
	parameter int unsigned WIDTH  = 4,
	parameter int unsigned STEADY = 3
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Sample strobe and raw inputs.
	input  wire logic             tick_i,
	input  wire logic [WIDTH-1:0] raw_i,
	// Accepted levels and one-cycle edge pulses.
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] fall_o
);
	logic [WIDTH-1:0] hist_q [STEADY];
	logic [WIDTH-1:0] hist_d [STEADY];
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] level_d;
	logic [WIDTH-1:0] rise_q;
	logic [WIDTH-1:0] fall_q;
	logic [WIDTH-1:0] same;

	localparam int unsigned FW = $clog2(STEADY + 1);

	logic [FW-1:0]    fill_q;
	logic [FW-1:0]    fill_d;
	logic             primed_q;
	logic             primed_d;

	if (WIDTH < 1 || STEADY < 2) begin : g_chk
		$error("input_filter: WIDTH >= 1 and STEADY >= 2 required");
	end

	// A level is accepted only after STEADY equal samples in a row.
	always_comb begin
		same = '1;
		for (int i = 1; i < STEADY; i++) begin
			same = same & ~(hist_q[i] ^ hist_q[0]);
		end
		hist_d = hist_q;
		if (tick_i) begin
			hist_d[0] = raw_i;
			for (int i = 1; i < STEADY; i++) begin
				hist_d[i] = hist_q[i-1];
			end
		end
		level_d = (same & hist_q[0]) | (~same & level_q);
		// Edges stay muted until every history slot holds a real sample,
		// so a pin that idles high does not look like a rise after reset.
		fill_d = fill_q;
		if (tick_i && fill_q != FW'(STEADY)) begin
			fill_d = fill_q + 1'b1;
		end
		primed_d = (fill_q == FW'(STEADY));
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < STEADY; i++) begin
				hist_q[i] <= '0;
			end
			level_q  <= '0;
			rise_q   <= '0;
			fall_q   <= '0;
			fill_q   <= '0;
			primed_q <= 1'b0;
		end else begin
			hist_q   <= hist_d;
			level_q  <= level_d;
			rise_q   <= {WIDTH{primed_q}} & level_d & ~level_q;
			fall_q   <= {WIDTH{primed_q}} & ~level_d & level_q;
			fill_q   <= fill_d;
			primed_q <= primed_d;
		end
	end

	assign level_o = level_q;
	assign rise_o  = rise_q;
	assign fall_o  = fall_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_level_steady: assert property (
		(level_q != $past(level_q)) |->
			($past(hist_q[0]) == $past(hist_q[STEADY-1])))
		else $error("filtered level changed without steady samples");
endmodule

/* File: verification/switch_model.sv */
`timescale 1ns/10ps
module switch_model #(
	parameter int GAP = 8
) (
	// Clock.
	input  wire logic                  clk_i,
	// Levels the bench asks for, and the levels on the pins.
	input  wire pump_io_pkg::pins_type want_i,
	output pump_io_pkg::pins_type      pins_o
);
	// Switches idle high; no change has happened yet.
	pump_io_pkg::pins_type pins_q = 4'hf;
	int                    age_q  = GAP;

	// A change waits until GAP cycles have passed since the last one.
	always @(posedge clk_i) begin
		age_q <= age_q + 1;
		if (want_i != pins_q && age_q >= GAP) begin
			pins_q <= want_i;
			age_q  <= 0;
		end
	end

	assign pins_o = pins_q;
endmodule

/* File: verification/pump_logic_io_control_bench.sv */
`timescale 1ns/10ps
module pump_logic_io_control_bench;
	logic                  clk        = 1'b0;
	logic                  rst_n      = 1'b0;
	logic [7:0]            adr        = 8'h00;
	logic                  rd         = 1'b0;
	logic                  we         = 1'b0;
	logic [31:0]           wdat       = 32'h0;
	logic [31:0]           rdat;
	logic                  wait_r;
	pump_io_pkg::pins_type want       = 4'hf;
	pump_io_pkg::pins_type pins;
	logic                  prog_o;
	logic                  motor_o;
	logic                  dir_o;
	int                    errors     = 0;
	int                    n_compared = 0;

	// A short sample period keeps each filtered edge to a few dozen cycles.
	pump_io_ctrl #(.SAMPLE_CYCLES(8)) i_dut (
		.MCLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(we), .AVS_WRITEDATA_I(wdat),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_r),
		.TRIG_I(pins.trig), .DIR_I(pins.dir), .EVENT_I(pins.evt),
		.PROG_I(pins.prog), .PROG_O(prog_o), .MOTOR_O(motor_o),
		.DIR_O(dir_o));

	// The far side spaces its edges by one sample period.
	switch_model #(.GAP(8)) i_sw (.clk_i(clk), .want_i(want), .pins_o(pins));

	// Clock at 125 MHz.
	always #4 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus cycle; the request stands until waitrequest is seen low.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		adr  <= a;
		wdat <= d;
		rd   <= !w;
		we   <= w;
		@(posedge clk);
		while (wait_r !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = rdat;
		rd <= 1'b0;
		we <= 1'b0;
		if (n >= 50) chk("bus answer", 32'h0, 32'h1);
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, e, q & m);
	endtask

	// Moving a pin waits long enough for three agreeing samples.
	task automatic pin(input int i, input logic v);
		want[i] <= v;
		repeat (48) @(posedge clk);
	endtask

	task automatic run(input logic r);
		rchk("running", 8'h08, 32'h10, {27'h0, r, 4'h0});
	endtask

	task automatic fall_trig();
		pin(0, 1'b1);
		pin(0, 1'b0);
	endtask

	task automatic outchk(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic test_reset();
		outchk("dir", 1'b1, dir_o);
		outchk("motor", 1'b0, motor_o);
		outchk("prog", 1'b0, prog_o);
		rchk("config", 8'h00, 32'hffffffff, 32'h0);
		rchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
		$display("test reset done");
	endtask

	task automatic test_trig();
		wr(8'h00, 32'h0);
		fall_trig();
		run(1'b1);
		fall_trig();
		run(1'b0);
		wr(8'h00, 32'h1);
		pin(0, 1'b1);
		run(1'b1);
		pin(0, 1'b0);
		run(1'b0);
		wr(8'h00, 32'h2);
		fall_trig();
		run(1'b1);
		rchk("permit", 8'h08, 32'h80, 32'h0);
		wr(8'h10, 32'h2);
		fall_trig();
		run(1'b0);
		wr(8'h10, 32'h200);
		rchk("permit", 8'h08, 32'h80, 32'h80);
		fall_trig();
		run(1'b1);
		wr(8'h00, 32'h3);
		fall_trig();
		run(1'b0);
		fall_trig();
		run(1'b0);
		$display("test trigger modes done");
	endtask

	task automatic test_ignore();
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		fall_trig();
		run(1'b0);
		wr(8'h04, 32'h2);
		fall_trig();
		run(1'b0);
		wr(8'h04, 32'h0);
		pin(0, 1'b1);
		want.trig <= 1'b0;
		repeat (9) @(posedge clk);
		want.trig <= 1'b1;
		repeat (48) @(posedge clk);
		run(1'b0);
		pin(0, 1'b0);
		run(1'b1);
		wr(8'h10, 32'h100);
		rchk("hold", 8'h08, 32'h30, 32'h20);
		fall_trig();
		rchk("resume", 8'h08, 32'h30, 32'h10);
		wr(8'h10, 32'h2);
		$display("test ignore and hold done");
	endtask

	task automatic test_motor();
		wr(8'h04, 32'h4);
		repeat (2) @(posedge clk);
		outchk("motor", 1'b1, motor_o);
		wr(8'h04, 32'h8);
		repeat (2) @(posedge clk);
		outchk("motor", 1'b0, motor_o);
		wr(8'h00, 32'h8);
		repeat (2) @(posedge clk);
		outchk("motor", 1'b1, motor_o);
		wr(8'h04, 32'h0);
		repeat (2) @(posedge clk);
		outchk("motor", 1'b0, motor_o);
		$display("test motor done");
	endtask

	task automatic test_dir();
		wr(8'h04, 32'h10);
		wr(8'h00, 32'h0);
		pin(1, 1'b0);
		outchk("dir", 1'b1, dir_o);
		pin(1, 1'b1);
		outchk("dir", 1'b0, dir_o);
		pin(1, 1'b0);
		outchk("dir", 1'b1, dir_o);
		wr(8'h00, 32'h4);
		pin(1, 1'b1);
		outchk("dir", 1'b1, dir_o);
		pin(1, 1'b0);
		outchk("dir", 1'b0, dir_o);
		pin(1, 1'b1);
		outchk("dir", 1'b1, dir_o);
		wr(8'h04, 32'h0);
		pin(1, 1'b0);
		outchk("dir", 1'b1, dir_o);
		$display("test direction done");
	endtask

	task automatic test_prog();
		wr(8'h0c, 32'h1);
		outchk("prog", 1'b1, prog_o);
		wr(8'h0c, 32'h0);
		outchk("prog", 1'b0, prog_o);
		rchk("inputs", 8'h08, 32'hf, {28'h0, want});
		pin(2, 1'b0);
		wr(8'h10, 32'h50010);
		rchk("jump", 8'h14, 32'hff01, 32'h501);
		rchk("armed", 8'h08, 32'h300, 32'h100);
		wr(8'h14, 32'h1);
		fall_trig();
		pin(2, 1'b1);
		pin(2, 1'b0);
		rchk("jump", 8'h14, 32'hff01, 32'h501);
		wr(8'h14, 32'h1);
		wr(8'h10, 32'h40);
		pin(2, 1'b1);
		pin(2, 1'b0);
		rchk("jump", 8'h14, 32'h1, 32'h0);
		wr(8'h10, 32'h70020);
		rchk("armed", 8'h08, 32'h300, 32'h200);
		pin(2, 1'b1);
		rchk("jump", 8'h14, 32'hff01, 32'h701);
		wr(8'h14, 32'h1);
		pin(2, 1'b0);
		rchk("jump", 8'h14, 32'hff01, 32'h701);
		wr(8'h14, 32'h1);
		wr(8'h10, 32'h40);
		wr(8'h10, 32'h90080);
		rchk("cond", 8'h14, 32'h1, 32'h0);
		pin(3, 1'b0);
		wr(8'h10, 32'h90080);
		rchk("cond", 8'h14, 32'hff01, 32'h901);
		$display("test program functions done");
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence; pins idle high through reset.
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (48) @(posedge clk);
		test_reset();
		test_trig();
		test_ignore();
		test_motor();
		test_dir();
		test_prog();
		print_verdict();
	end

	// The tests need about 2300 cycles; a hang stops well beyond that.
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		print_verdict();
	end
endmodule
